/* File: hw/flash_host_pkg.sv */
`default_nettype none

package flash_host_pkg;

    // -------------------------------------------------------------------
    // pin and counter widths
    // -------------------------------------------------------------------
    localparam int ADDR_W   = 18;
    localparam int CMD_AW   = 15;
    localparam int SECT_W   = 10;
    localparam int TIM_W    = 4;
    localparam int GAP_W    = 13;
    localparam int WC_W     = 21;
    localparam int CNT_W    = 9;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 20;
    localparam int WP_NS          = 200;
    localparam int WPH_NS         = 200;
    localparam int ACC_NS         = 120;
    localparam int OEHP_NS        = 150;
    localparam int LOAD_WIN_US    = 150;
    localparam int PROG_TIME_MS   = 20;
    localparam int WP_CYC   = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC  = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC  = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OEHP_CYC = (OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_WIN_CYC = (LOAD_WIN_US * 1000) / CLK_PERIOD_NS;
    localparam int PROG_TIME_CYC = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int LOAD_MARGIN_CYC = 2;

    // -------------------------------------------------------------------
    // sector and command codes
    // -------------------------------------------------------------------
    localparam logic [CNT_W-1:0]  SECTOR_BYTES  = 9'h100;
    localparam logic [CMD_AW-1:0] UNLOCK_ADDR_A = 15'h5555;
    localparam logic [CMD_AW-1:0] UNLOCK_ADDR_B = 15'h2aaa;
    localparam logic [CMD_AW-1:0] LOCK_HI_ADDR  = 15'h5555;
    localparam logic [7:0] UNLOCK_DATA_A = 8'haa;
    localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
    localparam logic [7:0] CODE_PROGRAM  = 8'ha0;
    localparam logic [7:0] CODE_ID_ENTER = 8'h90;
    localparam logic [7:0] CODE_ID_EXIT  = 8'hf0;
    localparam logic [7:0] CODE_LOCK_PRE = 8'h80;
    localparam logic [7:0] CODE_LOCK_LO  = 8'h40;
    localparam logic [7:0] CODE_LOCK_HI  = 8'h60;
    localparam int TOGGLE_BIT = 6;

    typedef enum logic [2:0] {
        OP_READ     = 3'h0,
        OP_ID_READ  = 3'h1,
        OP_PROGRAM  = 3'h2,
        OP_ID_ENTER = 3'h3,
        OP_ID_EXIT  = 3'h4,
        OP_LOCK_LO  = 3'h5,
        OP_LOCK_HI  = 3'h6
    } op_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
    } req_t;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        dq;
        logic              dq_oe_n;
    } flash_out_t;

    // -------------------------------------------------------------------
    // command sequence tables
    // -------------------------------------------------------------------
    function automatic logic [2:0] seq_len(input op_t op);
        seq_len = (op == OP_LOCK_LO || op == OP_LOCK_HI) ? 3'h6 : 3'h3;
    endfunction : seq_len

    function automatic logic [CMD_AW-1:0] seq_addr(input op_t op,
                                                   input logic [2:0] idx);
        unique case (idx)
            3'h1, 3'h4: seq_addr = UNLOCK_ADDR_B;
            3'h5: seq_addr = (op == OP_LOCK_HI) ? LOCK_HI_ADDR : UNLOCK_ADDR_A;
            default: seq_addr = UNLOCK_ADDR_A;
        endcase
    endfunction : seq_addr

    function automatic logic [7:0] seq_data(input op_t op,
                                            input logic [2:0] idx);
        unique case (idx)
            3'h0, 3'h3: seq_data = UNLOCK_DATA_A;
            3'h1, 3'h4: seq_data = UNLOCK_DATA_B;
            3'h2:
                unique case (op)
                    OP_ID_ENTER: seq_data = CODE_ID_ENTER;
                    OP_ID_EXIT:  seq_data = CODE_ID_EXIT;
                    OP_PROGRAM:  seq_data = CODE_PROGRAM;
                    default:     seq_data = CODE_LOCK_PRE;
                endcase
            default: seq_data = (op == OP_LOCK_HI) ? CODE_LOCK_HI
                                                   : CODE_LOCK_LO;
        endcase
    endfunction : seq_data

endpackage : flash_host_pkg

`default_nettype wire

/* File: hw/flash_sector_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - each byte load shows the sector number on the upper address bits.
// - every byte of the sector is loaded unless the load window runs out first.
// - 256 data bytes are written before programming may start, fewer when a gap ends loading.
// - byte loads follow within the load window; longer gaps end loading.
// - only a change of the toggle bit between reads is looked at.
// - status polling keeps one constant address for all reads.
// - commands use eight data lines and fifteen low address bits.
module flash_sector_host #(
    parameter int unsigned LOAD_WINDOW_CYC = flash_host_pkg::LOAD_WIN_CYC,
    parameter int unsigned PROG_TIMEOUT_CYC = flash_host_pkg::PROG_TIME_CYC
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // request port
    input  wire logic                       req_valid,
    input  wire flash_host_pkg::req_t       req,
    output var  logic                       req_ready,
    output var  logic                       done,
    output var  logic                       err,
    output var  logic [7:0]                 rd_data,
    // sector byte stream
    input  wire logic                       load_valid,
    input  wire logic [7:0]                 load_data,
    output var  logic                       load_ready,
    // flash pins
    output var  flash_host_pkg::flash_out_t flash_o,
    input  wire logic [7:0]                 dq_in
);
    import flash_host_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_WLOW  = 7'b0000010,
        ST_WHIGH = 7'b0000100,
        ST_LOAD  = 7'b0001000,
        ST_RD    = 7'b0010000,
        ST_RGAP  = 7'b0100000,
        ST_DONE  = 7'b1000000
    } state_t;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    state_t            state;
    state_t            next_state;
    op_t               op;
    op_t               next_op;
    logic [TIM_W-1:0]  tim;
    logic [TIM_W-1:0]  next_tim;
    logic [2:0]        seq_idx;
    logic [2:0]        next_seq_idx;
    logic [CNT_W-1:0]  byte_cnt;
    logic [CNT_W-1:0]  next_byte_cnt;
    logic [SECT_W-1:0] sector;
    logic [SECT_W-1:0] next_sector;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0]        dq;
    logic [7:0]        next_dq;
    logic [GAP_W-1:0]  gap;
    logic [GAP_W-1:0]  next_gap;
    logic [WC_W-1:0]   wc;
    logic [WC_W-1:0]   next_wc;
    logic              prev_toggle;
    logic              next_prev_toggle;
    logic              have_prev;
    logic              next_have_prev;
    logic              next_err;
    logic [7:0]        next_rd_data;

    // -------------------------------------------------------------------
    // decode
    // -------------------------------------------------------------------
    wire logic tim_zero    = (tim == '0);
    wire logic seq_more    = (3'(seq_idx + 3'h1) < seq_len(op));
    wire logic is_program  = (op == OP_PROGRAM);
    wire logic sector_full = (byte_cnt == SECTOR_BYTES);
    wire logic gap_over    =
        (gap >= GAP_W'(LOAD_WINDOW_CYC - LOAD_MARGIN_CYC));
    wire logic wc_over     = (wc >= WC_W'(PROG_TIMEOUT_CYC));
    wire logic toggle_now  = dq_in[TOGGLE_BIT];
    wire logic drive_ce    = (next_state == ST_WLOW) || (next_state == ST_RD);
    wire logic drive_dq    =
        (next_state == ST_WLOW) || (next_state == ST_WHIGH);

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb
    begin
        next_state       = state;
        next_op          = op;
        next_tim         = tim_zero ? tim : TIM_W'(tim - 1'b1);
        next_seq_idx     = seq_idx;
        next_byte_cnt    = byte_cnt;
        next_sector      = sector;
        next_addr        = addr;
        next_dq          = dq;
        next_wc          = wc_over ? wc : WC_W'(wc + 1'b1);
        next_prev_toggle = prev_toggle;
        next_have_prev   = have_prev;
        next_err         = err;
        next_rd_data     = rd_data;
        unique case (state)
            ST_IDLE:
                if (req_valid)
                begin
                    next_op       = req.op;
                    next_err      = 1'b0;
                    next_seq_idx  = '0;
                    next_byte_cnt = '0;
                    next_sector   = req.addr[ADDR_W-1:ADDR_W-SECT_W];
                    if (req.op == OP_READ)
                    begin
                        next_addr  = req.addr;
                        next_tim   = TIM_W'(ACC_CYC - 1);
                        next_state = ST_RD;
                    end
                    else if (req.op == OP_ID_READ)
                    begin
                        next_addr  = {{(ADDR_W-1){1'b0}},
                                      req.addr[0]};
                        next_tim   = TIM_W'(ACC_CYC - 1);
                        next_state = ST_RD;
                    end
                    else
                    begin
                        // every command opens with the unlock, program too
                        next_addr  =
                            ADDR_W'(seq_addr(req.op, 3'h0));
                        next_dq    = seq_data(req.op, 3'h0);
                        next_tim   = TIM_W'(WP_CYC - 1);
                        next_state = ST_WLOW;
                    end
                end
            ST_WLOW:
                if (tim_zero)
                begin
                    next_tim   = TIM_W'(WPH_CYC - 1);
                    next_state = ST_WHIGH;
                end
            ST_WHIGH:
                if (tim_zero)
                begin
                    if (seq_more)
                    begin
                        next_seq_idx = 3'(seq_idx + 3'h1);
                        // entry, exit, program and lockout steps
                        next_addr  =
                            ADDR_W'(seq_addr(op, next_seq_idx));
                        next_dq    = seq_data(op, next_seq_idx);
                        next_tim   = TIM_W'(WP_CYC - 1);
                        next_state = ST_WLOW;
                    end
                    else if (is_program && !sector_full)
                        next_state = ST_LOAD;
                    else if (is_program)
                    begin
                        // poll at the last loaded address, never moved
                        next_have_prev = 1'b0;
                        next_wc        = '0;
                        next_tim       = TIM_W'(ACC_CYC - 1);
                        next_state     = ST_RD;
                    end
                    else
                        next_state = ST_DONE;
                end
            ST_LOAD:
                if (load_valid)
                begin
                    next_addr     = {sector, byte_cnt[7:0]};
                    next_dq       = load_data;
                    next_byte_cnt = CNT_W'(byte_cnt + 1'b1);
                    next_tim      = TIM_W'(WP_CYC - 1);
                    next_state    = ST_WLOW;
                end
                else if (gap_over)
                begin
                    // source starved: device will program a partial sector
                    next_err       = 1'b1;
                    next_have_prev = 1'b0;
                    next_wc        = '0;
                    next_tim       = TIM_W'(ACC_CYC - 1);
                    next_state     = ST_RD;
                end
            ST_RD:
                if (tim_zero)
                begin
                    next_rd_data = dq_in;
                    if (!is_program)
                        next_state = ST_DONE;
                    else if (have_prev && toggle_now == prev_toggle)
                        next_state = ST_DONE;
                    else
                    begin
                        next_prev_toggle = toggle_now;
                        next_have_prev   = 1'b1;
                        next_tim         = TIM_W'(OEHP_CYC - 1);
                        next_state       = ST_RGAP;
                    end
                end
            ST_RGAP:
                if (wc_over)
                begin
                    next_err   = 1'b1;
                    next_state = ST_DONE;
                end
                else if (tim_zero)
                begin
                    next_tim   = TIM_W'(ACC_CYC - 1);
                    next_state = ST_RD;
                end
            ST_DONE:
                next_state = ST_IDLE;
        endcase
    end

    // falling write strobe to falling write strobe
    assign next_gap = (next_state == ST_WLOW && state != ST_WLOW) ? '0
                    : (gap_over ? gap : GAP_W'(gap + 1'b1));

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state       <= ST_IDLE;
            op          <= OP_READ;
            tim         <= '0;
            seq_idx     <= '0;
            byte_cnt    <= '0;
            sector      <= '0;
            addr        <= '0;
            dq          <= '0;
            gap         <= '0;
            wc          <= '0;
            prev_toggle <= 1'b0;
            have_prev   <= 1'b0;
            err         <= 1'b0;
            rd_data     <= '0;
            done        <= 1'b0;
            req_ready   <= 1'b0;
            load_ready  <= 1'b0;
            flash_o     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                             addr: '0, dq: '0, dq_oe_n: 1'b1};
        end
        else
        begin
            state       <= next_state;
            op          <= next_op;
            tim         <= next_tim;
            seq_idx     <= next_seq_idx;
            byte_cnt    <= next_byte_cnt;
            sector      <= next_sector;
            addr        <= next_addr;
            dq          <= next_dq;
            gap         <= next_gap;
            wc          <= next_wc;
            prev_toggle <= next_prev_toggle;
            have_prev   <= next_have_prev;
            err         <= next_err;
            rd_data     <= next_rd_data;
            done        <= (next_state == ST_DONE);
            req_ready   <= (next_state == ST_IDLE);
            load_ready  <= (next_state == ST_LOAD);
            flash_o     <= '{ce_n: !drive_ce,
                             oe_n: (next_state != ST_RD),
                             we_n: (next_state != ST_WLOW),
                             addr: next_addr,
                             dq: next_dq,
                             dq_oe_n: !drive_dq};
        end
    end

endmodule : flash_sector_host

`default_nettype wire

/* File: test/flash_sector_host_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------
// port checks of the sector flash host
// -------------------------------------------------
module flash_sector_host_checker
    import flash_host_pkg::*;
#(
    parameter int unsigned LOAD_WINDOW_CYC  = 64,
    parameter int unsigned PROG_TIMEOUT_CYC = 2000
) (
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       rst,
    // request port
    input wire logic                       req_valid,
    input wire flash_host_pkg::req_t       req,
    input wire logic                       req_ready,
    input wire logic                       done,
    input wire logic                       err,
    input wire logic [7:0]                 rd_data,
    // byte stream
    input wire logic                       load_valid,
    input wire logic [7:0]                 load_data,
    input wire logic                       load_ready,
    // flash pins
    input wire flash_host_pkg::flash_out_t flash_o,
    input wire logic [7:0]                 dq_in
);
    logic        in_prog;
    logic        we_q;
    logic        oe_q;
    logic [8:0]  n_load;
    logic [9:0]  sect;
    logic [1:0]  n_rd;
    logic [17:0] poll_adr;
    int unsigned gap;
    wire logic   take    = load_valid && load_ready;
    wire logic   oe_fall = oe_q && !flash_o.oe_n;
    wire logic   we_fall = we_q && !flash_o.we_n;

    always_ff @(posedge sys_clk)
    begin
        we_q <= flash_o.we_n;
        oe_q <= flash_o.oe_n;
        gap  <= we_fall ? 0 : gap + 1;
        if (take)
            n_load <= n_load + 9'h1;
        if (oe_fall)
            poll_adr <= flash_o.addr;
        if (oe_fall && n_rd != 2'h3)
            n_rd <= n_rd + 2'h1;
        if (req_valid && req_ready)
        begin
            in_prog <= req.op == OP_PROGRAM;
            sect    <= req.addr[17:8];
            n_load  <= 9'h0;
            n_rd    <= 2'h0;
        end
        if (rst)
            in_prog <= 1'b0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sector_addr_a: assert property (
        take |=> !flash_o.we_n && !flash_o.ce_n && flash_o.addr[17:8] == sect)
        else $error("byte strobe off sector");
    byte_index_a: assert property (
        take |=> flash_o.addr[7:0] == n_load[7:0] - 8'h1)
        else $error("byte at wrong index");
    byte_count_a: assert property (
        load_ready |-> n_load < 9'h100)
        else $error("too many bytes asked");
    load_gap_a: assert property (
        in_prog && we_fall && n_load > 9'h1 |-> gap < LOAD_WINDOW_CYC)
        else $error("byte loads too far apart");
    poll_addr_a: assert property (
        in_prog && oe_fall && n_rd != 2'h0 |-> flash_o.addr == poll_adr)
        else $error("poll address moved");
    poll_done_a: assert property (
        in_prog && done && !err |-> n_rd >= 2'h2)
        else $error("done before two polls");
    cmd_write_a: assert property (
        !in_prog && !flash_o.we_n |->
            flash_o.addr[17:15] == 3'h0 && flash_o.oe_n && !flash_o.dq_oe_n)
        else $error("bad command write");
    write_pulse_a: assert property (
        we_fall |-> (!flash_o.we_n && !flash_o.ce_n)[*8]
            ##1 !flash_o.we_n ##1 !flash_o.we_n ##1 flash_o.we_n)
        else $error("write strobe not ten cycles");

    cover property (take && n_load == 9'hff);
    cover property (in_prog && done && err);
    cover property (in_prog && done && !err);
endmodule : flash_sector_host_checker

bind flash_sector_host flash_sector_host_checker #(
    .LOAD_WINDOW_CYC(LOAD_WINDOW_CYC), .PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC)
) chk (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .err(err), .rd_data(rd_data),
    .load_valid(load_valid), .load_data(load_data),
    .load_ready(load_ready), .flash_o(flash_o), .dq_in(dq_in));
`default_nettype wire

/* File: test/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------
// behavioural sector flash
// -------------------------------------------------
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter int unsigned WIN_CYC  = 64,
    parameter int unsigned BUSY_CYC = 500,
    parameter logic [7:0]  MAKER    = 8'h3c, // arbitrary value
    parameter logic [7:0]  PART     = 8'hc3  // arbitrary value
) (
    // clock and power-up
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // flash pins
    input  wire flash_host_pkg::flash_out_t flash_o,
    output var  logic [7:0]                 dq_in
);
    logic [7:0]   mem [int];
    logic [7:0]   page [256];
    logic [255:0] got;
    logic [9:0]   sect;
    logic [2:0]   seq;
    logic         loading;
    logic         id_mode;
    logic         lock_lo = 1'b0;
    logic         lock_hi = 1'b0;
    logic         tog     = 1'b0;
    logic         wr_q;
    logic         rd_q;
    int unsigned  gap;
    int unsigned  busy;
    wire logic    wr   = !flash_o.ce_n && !flash_o.we_n;
    wire logic    rd   = !flash_o.ce_n && !flash_o.oe_n;
    wire logic    hold = loading || busy != 0;
    wire logic    lckd = (lock_lo && sect < 10'h20) ||
                         (lock_hi && sect >= 10'h3e0);
    wire logic    ok_a = flash_o.addr[14:0] == UNLOCK_ADDR_A;
    wire logic    ok_b = flash_o.addr[14:0] == UNLOCK_ADDR_B;
    wire logic    id_a = id_mode && flash_o.addr[17:1] == 17'h0;
    wire logic [7:0] d = flash_o.dq;

    function automatic logic [7:0] peek(input logic [17:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
    endfunction : peek

    always @(posedge sys_clk)
    begin
        wr_q <= wr;
        rd_q <= rd;
        if (rd && !rd_q && hold)
            tog <= !tog;
        if (loading)
            gap <= gap + 1;
        if (loading && gap >= WIN_CYC)
        begin
            loading <= 1'b0;
            busy    <= BUSY_CYC;
        end
        if (busy != 0)
            busy <= busy - 1;
        if (busy == 1 && !lckd)
            for (int i = 0; i < 256; i++)
                mem[{sect, i[7:0]}] = got[i] ? page[i] : 8'h00;
        if (wr && !wr_q && loading)
        begin
            page[flash_o.addr[7:0]] <= d;
            got[flash_o.addr[7:0]]  <= 1'b1;
            sect <= flash_o.addr[17:8];
            gap  <= 0;
        end
        else if (wr && !wr_q && busy == 0)
            case (seq)
                3'h0, 3'h3:
                    seq <= ok_a && d == UNLOCK_DATA_A ? seq + 3'h1 : 3'h0;
                3'h1, 3'h4:
                    seq <= ok_b && d == UNLOCK_DATA_B ? seq + 3'h1 : 3'h0;
                3'h2:
                begin
                    seq     <= (d == CODE_LOCK_PRE) ? 3'h3 : 3'h0;
                    loading <= d == CODE_PROGRAM;
                    got     <= '0;
                    gap     <= 0;
                    id_mode <= d == CODE_ID_ENTER ||
                               (id_mode && d != CODE_ID_EXIT);
                end
                default:
                begin
                    seq     <= 3'h0;
                    lock_lo <= lock_lo || d == CODE_LOCK_LO;
                    lock_hi <= lock_hi || d == CODE_LOCK_HI;
                end
            endcase
        if (rst)
        begin
            seq     <= 3'h0;
            loading <= 1'b0;
            busy    <= 0;
            id_mode <= 1'b0;
        end
        // released data lines show a changing pattern
        dq_in <= rst ? 8'h5a : !rd ? ~dq_in : hold ? {1'b0, tog, 6'h00} :
                 id_a ? (flash_o.addr[0] ? PART : MAKER) :
                 peek(flash_o.addr);
    end
endmodule : flash_dev_model
`default_nettype wire

/* File: test/sector_flash_program_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------
// self-checking bench
// -------------------------------------------------
module sector_flash_program_control_bench;
    import flash_host_pkg::*;
    localparam int unsigned WIN   = 64;
    localparam logic [7:0]  MAKER = 8'h3c; // arbitrary value
    localparam logic [7:0]  PART  = 8'hc3; // arbitrary value
    logic        sys_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic        req_valid  = 1'b0;
    logic        load_valid = 1'b0;
    logic [7:0]  load_data  = 8'h00;
    req_t        req        = '0;
    logic        req_ready;
    logic        done;
    logic        err;
    logic        load_ready;
    logic [7:0]  rd_data;
    logic [7:0]  dq_in;
    flash_out_t  flash_o;
    logic [7:0]  exp_mem [int];
    logic [7:0]  pg [256];
    logic        lk = 1'b0;
    logic [17:0] a;
    logic [9:0]  s;
    int          errors  = 0;
    int          n_tests = 0;

    flash_sector_host #(.LOAD_WINDOW_CYC(WIN), .PROG_TIMEOUT_CYC(2000)) uut (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .err(err), .rd_data(rd_data),
        .load_valid(load_valid), .load_data(load_data),
        .load_ready(load_ready), .flash_o(flash_o), .dq_in(dq_in));
    flash_dev_model #(.WIN_CYC(WIN), .MAKER(MAKER), .PART(PART)) dev (
        .sys_clk(sys_clk), .rst(rst), .flash_o(flash_o), .dq_in(dq_in));

    initial
        forever #10 sys_clk = ~sys_clk;

    function automatic logic [7:0] ex(input logic [17:0] ad);
        return exp_mem.exists(int'(ad)) ? exp_mem[int'(ad)] : 8'hff;
    endfunction : ex
    function automatic logic locked(input logic [9:0] sc);
        return lk && (sc < 10'h20 || sc >= 10'h3e0);
    endfunction : locked

    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_for(input int w);
        for (int k = 0; k < 30000; k++)
        begin
            @(posedge sys_clk);
            if ((w == 0 && req_ready === 1'b1)
                || (w == 1 && load_ready === 1'b1)
                || (w == 2 && done === 1'b1))
                return;
        end
        errors++;
        finish_test();
    endtask : wait_for
    task automatic do_reset();
        rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
    endtask : do_reset
    task automatic run(input op_t op, input logic [17:0] ad, input int stall);
        req.op    <= op;
        req.addr  <= ad;
        req_valid <= 1'b1;
        wait_for(0);
        req_valid <= 1'b0;
        for (int k = 0; op == OP_PROGRAM && k < 256 && k != stall; k++)
        begin
            load_data  <= pg[k];
            load_valid <= 1'b1;
            wait_for(1);
        end
        load_valid <= 1'b0;
        wait_for(2);
    endtask : run
    task automatic rd_chk(input op_t op, input logic [17:0] ad,
                          input logic [7:0] e);
        run(op, ad, -1);
        check("read", rd_data, e);
    endtask : rd_chk
    task automatic prog(input logic [9:0] sc, input int stall);
        for (int k = 0; k < 256; k++)
            pg[k] = 8'($urandom);
        run(OP_PROGRAM, {sc, 8'h00}, stall);
        check("prog err", {7'h0, err}, {7'h0, stall >= 0});
        if (stall < 0)
            check("poll", rd_data,
                  locked(sc) ? ex({sc, 8'hff}) : pg[255]);
        for (int k = 0; k < 256; k++)
            if (stall < 0 && !locked(sc))
                exp_mem[{sc, k[7:0]}] = pg[k];
    endtask : prog

    initial
    begin
        void'($urandom(32'hcd9d44a9));
        do_reset();
        a = 18'($urandom);
        rd_chk(OP_READ, a, 8'hff);
        run(OP_ID_ENTER, 18'h0, -1);
        rd_chk(OP_ID_READ, 18'h0, MAKER);
        rd_chk(OP_ID_READ, 18'h1, PART);
        run(OP_ID_EXIT, 18'h0, -1);
        rd_chk(OP_READ, 18'h1, 8'hff);
        run(OP_ID_ENTER, 18'h0, -1);
        do_reset();
        rd_chk(OP_READ, 18'h0, 8'hff);
        s = 10'h20 + 10'($urandom % 960);
        prog(s, -1);
        prog(s, -1);
        for (int i = 0; i < 6; i++)
        begin
            a = {s, (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom)};
            rd_chk(OP_READ, a, ex(a));
        end
        run(OP_LOCK_LO, 18'h0, -1);
        run(OP_LOCK_HI, 18'h0, -1);
        lk = 1'b1;
        prog(10'h000, -1);
        prog(10'h3ff, -1);
        rd_chk(OP_READ, 18'h00010, 8'hff);
        rd_chk(OP_READ, 18'h3ff80, 8'hff);
        prog(s ^ 10'h001, 100);
        rd_chk(OP_READ, a, ex(a));
        check("err clear", {7'h0, err}, 8'h00);
        finish_test();
    end
endmodule : sector_flash_program_control_bench
`default_nettype wire
